// *** hdl/fpom_consts.svh ***
/*
 constants of the parameter object map: object indices, subindices, reset values, command codes.
 assumes inclusion by bare name from design files.
*/
`ifndef FPOM_CONSTS_SVH
`define FPOM_CONSTS_SVH
`define FPOM_OBJ_COMMAND 16'h0010
`define FPOM_OBJ_MODULE 16'h0011
`define FPOM_OBJ_MOTOR 16'h0012
`define FPOM_SUB_HW_HIGH 8'h01
`define FPOM_SUB_HW_LOW 8'h02
`define FPOM_SUB_NET_ADDR 8'h03
`define FPOM_SUB_NET_MASK 8'h04
`define FPOM_SUB_GATEWAY 8'h05
`define FPOM_SUB_SETUP 8'h06
`define FPOM_SUB_DOUT 8'h07
`define FPOM_SUB_CMD_WORD 8'h0F
`define FPOM_SUB_TX_FIRST 8'h10
`define FPOM_SUB_TX_LAST 8'h14
`define FPOM_SUB_RX_FIRST 8'h18
`define FPOM_SUB_RX_LAST 8'h1C
`define FPOM_SUB_SERIAL 8'h20
`define FPOM_SUB_HW_VER 8'h21
`define FPOM_SUB_SW_VER 8'h22
`define FPOM_SUB_CNT_FIRST 8'h23
`define FPOM_SUB_CNT_LAST 8'h26
`define FPOM_SUB_DIN 8'h2F
`define FPOM_SUB_STATUS 8'h30
`define FPOM_NODE_ID_BITS 8
`define FPOM_HW_HIGH_BITS 16
`define FPOM_SETUP_RESET 32'h00000000
`define FPOM_DOUT_RESET 32'h00000000
`define FPOM_TX_RESET {32'h00000023, 32'h000000A9, 32'h0000000C, 32'h0000000A, 32'h00000002}
`define FPOM_RX_RESET {32'h00000000, 32'h00000007, 32'h00000005, 32'h00000003, 32'h00000002}
`define FPOM_CMD_SAVE_FLASH 32'h00000010
`endif

// *** hdl/fpom_pkg.sv ***
/*
 types of the parameter object map.
 assumes nothing beyond a systemverilog compiler.
*/
package fpom_pkg;
    typedef logic [31:0] fpom_word_t;
    typedef enum logic [1:0] {FPOM_RESP_OK, FPOM_RESP_DENIED, FPOM_RESP_UNMAPPED} fpom_resp_t;
endpackage : fpom_pkg

// *** hdl/fpom_event_counter.sv ***
/*
 one diagnostic event counter.
 assumes the event input is already on the clock's domain.
*/
`timescale 1ns/1ns
`default_nettype none
module fpom_event_counter #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // event and count
    input wire logic event_pulse,
    output logic [WIDTH-1:0] count
);
    // step by one per event, wrap silently at the top
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            count <= '0;
        else if (event_pulse)
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
endmodule : fpom_event_counter
`default_nettype wire

// *** hdl/fpom_object_map.sv ***
/*
 parameter object map: module command, module parameters, window onto the motor registers.
 assumes one acyclic request per strobe from the network side, events and motor answers from
 same-clock logic, and digital inputs from pins (synchronised here).
*/
`include "fpom_consts.svh"
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - command object at index 0x10 subindex 0 takes written 32-bit words as commands.
// - hardware address high 16 bits at subindex 1, low 32 bits at 2, read-only.
// - subindex 3 writable network address, low byte is node id; 4, 5 read-only.
// - setup bits at 6 and digital outputs at 7 reset to zero, writable.
// - subindices 16-20 pick transmit map registers, defaults 2, 10, 12, 169, 35.
// - subindices 24-28 pick receive map registers, defaults 2, 3, 5, 7, 0.
// - subindices 8-14, 21-23, 29-31, 39-46, 49-63 are reserved, no function.
// - subindices 35-38 count link timeouts, retries, discards and total frames, read-only.
// - inputs at 47, status at 48, serial and versions at 32-34, all read-only.
// - index 0x12 subindex n reaches motor register n for n in 0 to 255.
// - parameter changes are not saved to storage until the save command.
// - writing 16 to the command object saves module parameters to flash.
// - a new cyclic selection never reaches the active maps; reset reloads the fixed defaults.
module fpom_object_map
    import fpom_pkg::*;
#(
    parameter logic [31:0] HW_ADDR_HIGH = 32'h00001234, // arbitrary value
    parameter logic [31:0] HW_ADDR_LOW = 32'h56789ABC, // arbitrary value
    parameter logic [31:0] NET_MASK = 32'hFFFFFF00,
    parameter logic [31:0] GATEWAY = 32'h00000000,
    parameter logic [31:0] SERIAL_NUMBER = 32'h00000001, // arbitrary value
    parameter logic [31:0] HW_VERSION = 32'h00000001, // arbitrary value
    parameter logic [31:0] SW_VERSION = 32'h00000001, // arbitrary value
    parameter int MAP_POSITIONS = 5
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // acyclic parameter request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [15:0] req_index,
    input wire logic [7:0] req_subindex,
    input wire logic [31:0] req_wdata,
    // acyclic parameter answer
    output logic resp_valid,
    output fpom_pkg::fpom_resp_t resp_code,
    output logic [31:0] resp_rdata,
    // motor register window
    output logic motor_req,
    output logic motor_write,
    output logic [7:0] motor_reg,
    output logic [31:0] motor_wdata,
    input wire logic motor_ack,
    input wire logic [31:0] motor_rdata,
    // flash copy
    output logic save_request,
    input wire logic save_done,
    // node state and pins
    output logic [31:0] net_address_node,
    output logic [7:0] node_id,
    output logic [31:0] setup_bits,
    output logic [31:0] digital_outputs,
    output logic [31:0] command_word,
    input wire logic [31:0] digital_inputs_pin,
    input wire logic [31:0] status_bits,
    // active cyclic selection, loaded only at reset (power cycle)
    output logic [MAP_POSITIONS*32-1:0] transmit_process_map,
    output logic [MAP_POSITIONS*32-1:0] receive_process_map,
    // motor link events
    input wire logic link_timeout_evt,
    input wire logic retry_frame_evt,
    input wire logic discard_frame_evt,
    input wire logic total_frame_evt
);
    import fpom_pkg::*;

    logic [31:0] tx_sel [MAP_POSITIONS];
    logic [31:0] rx_sel [MAP_POSITIONS];
    logic [31:0] counts [4];
    logic [31:0] din_meta;
    logic [31:0] digital_inputs;
    logic motor_busy;
    logic next_ok;
    logic next_writable;
    logic [31:0] next_rdata;
    logic is_mod;
    logic is_cmd;
    logic is_motor;
    logic wr_mod;
    logic [MAP_POSITIONS*32-1:0] tx_reset_all;
    logic [MAP_POSITIONS*32-1:0] rx_reset_all;

    assign tx_reset_all = `FPOM_TX_RESET;
    assign rx_reset_all = `FPOM_RX_RESET;
    assign is_cmd = (req_index == `FPOM_OBJ_COMMAND) && (req_subindex == 8'h00);
    assign is_mod = (req_index == `FPOM_OBJ_MODULE);
    assign is_motor = (req_index == `FPOM_OBJ_MOTOR);
    // only accepted writes reach storage; denied ones fall out here
    assign wr_mod = req_valid && req_write && is_mod && next_ok && next_writable;

    // pins pass two flops before anything looks at them
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            din_meta <= '0;
            digital_inputs <= '0;
        end
        else
        begin
            din_meta <= digital_inputs_pin;
            digital_inputs <= din_meta;
        end
    end

    // decode of the module parameter subindex: existence, writability, read data
    always_comb
    begin
        next_ok = 1'b1;
        next_writable = 1'b0;
        next_rdata = 32'h00000000;
        case (req_subindex)
            `FPOM_SUB_HW_HIGH: next_rdata = {16'h0000, HW_ADDR_HIGH[`FPOM_HW_HIGH_BITS-1:0]};
            `FPOM_SUB_HW_LOW: next_rdata = HW_ADDR_LOW;
            `FPOM_SUB_NET_ADDR:
            begin
                next_rdata = net_address_node;
                next_writable = 1'b1;
            end
            `FPOM_SUB_NET_MASK: next_rdata = NET_MASK;
            `FPOM_SUB_GATEWAY: next_rdata = GATEWAY;
            `FPOM_SUB_SETUP:
            begin
                next_rdata = setup_bits;
                next_writable = 1'b1;
            end
            `FPOM_SUB_DOUT:
            begin
                next_rdata = digital_outputs;
                next_writable = 1'b1;
            end
            `FPOM_SUB_CMD_WORD:
            begin
                next_rdata = command_word;
                next_writable = 1'b1;
            end
            `FPOM_SUB_SERIAL: next_rdata = SERIAL_NUMBER;
            `FPOM_SUB_HW_VER: next_rdata = HW_VERSION;
            `FPOM_SUB_SW_VER: next_rdata = SW_VERSION;
            `FPOM_SUB_DIN: next_rdata = digital_inputs;
            `FPOM_SUB_STATUS: next_rdata = status_bits;
            default:
            begin
                if (req_subindex >= `FPOM_SUB_TX_FIRST && req_subindex <= `FPOM_SUB_TX_LAST)
                begin
                    next_rdata = tx_sel[3'(req_subindex - `FPOM_SUB_TX_FIRST)];
                    next_writable = 1'b1;
                end
                else if (req_subindex >= `FPOM_SUB_RX_FIRST && req_subindex <= `FPOM_SUB_RX_LAST)
                begin
                    next_rdata = rx_sel[3'(req_subindex - `FPOM_SUB_RX_FIRST)];
                    next_writable = 1'b1;
                end
                else if (req_subindex >= `FPOM_SUB_CNT_FIRST && req_subindex <= `FPOM_SUB_CNT_LAST)
                    next_rdata = counts[2'(req_subindex - `FPOM_SUB_CNT_FIRST)];
                else
                    next_ok = 1'b0; // reserved subindex, no function
            end
        endcase
    end

    // writable module parameters; volatile until the save command
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            net_address_node <= 32'h00000000;
            setup_bits <= `FPOM_SETUP_RESET;
            digital_outputs <= `FPOM_DOUT_RESET;
            command_word <= 32'h00000000;
        end
        else if (wr_mod)
        begin
            case (req_subindex)
                `FPOM_SUB_NET_ADDR: net_address_node <= req_wdata;
                `FPOM_SUB_SETUP: setup_bits <= req_wdata;
                `FPOM_SUB_DOUT: digital_outputs <= req_wdata;
                `FPOM_SUB_CMD_WORD: command_word <= req_wdata;
                default: ;
            endcase
        end
    end

    assign node_id = net_address_node[`FPOM_NODE_ID_BITS-1:0];

    // selection words per map position, defaults per position
    genvar gp;
    generate
        for (gp = 0; gp < MAP_POSITIONS; gp++)
        begin : g_map
            always_ff @(posedge clock)
            begin
                if (!reset_n)
                begin
                    tx_sel[gp] <= tx_reset_all[gp*32 +: 32];
                    rx_sel[gp] <= rx_reset_all[gp*32 +: 32];
                end
                else if (wr_mod && req_subindex == `FPOM_SUB_TX_FIRST + 8'(gp))
                    tx_sel[gp] <= req_wdata;
                else if (wr_mod && req_subindex == `FPOM_SUB_RX_FIRST + 8'(gp))
                    rx_sel[gp] <= req_wdata;
            end
            // the active map loads the fixed defaults only while reset is held: a new choice never reaches it
            always_ff @(posedge clock)
            begin
                if (!reset_n)
                begin
                    transmit_process_map[gp*32 +: 32] <= tx_reset_all[gp*32 +: 32];
                    receive_process_map[gp*32 +: 32] <= rx_reset_all[gp*32 +: 32];
                end
            end
        end
    endgenerate

    // diagnostic counters
    fpom_event_counter #(.WIDTH(32)) u_cnt_timeout (.clock(clock), .reset_n(reset_n),
        .event_pulse(link_timeout_evt), .count(counts[0]));
    fpom_event_counter #(.WIDTH(32)) u_cnt_retry (.clock(clock), .reset_n(reset_n),
        .event_pulse(retry_frame_evt), .count(counts[1]));
    fpom_event_counter #(.WIDTH(32)) u_cnt_discard (.clock(clock), .reset_n(reset_n),
        .event_pulse(discard_frame_evt), .count(counts[2]));
    fpom_event_counter #(.WIDTH(32)) u_cnt_total (.clock(clock), .reset_n(reset_n),
        .event_pulse(total_frame_evt), .count(counts[3]));

    // save request: held until the flash side reports done
    always_ff @(posedge clock)
    begin
        if (!reset_n)
            save_request <= 1'b0;
        else if (req_valid && req_write && is_cmd && req_wdata == `FPOM_CMD_SAVE_FLASH)
            save_request <= 1'b1;
        else if (save_done)
            save_request <= 1'b0;
    end

    // motor window: forward and hold until the motor side acknowledges
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            motor_busy <= 1'b0;
            motor_req <= 1'b0;
            motor_write <= 1'b0;
            motor_reg <= 8'h00;
            motor_wdata <= 32'h00000000;
        end
        else if (!motor_busy && req_valid && is_motor)
        begin
            motor_busy <= 1'b1;
            motor_req <= 1'b1;
            motor_write <= req_write;
            motor_reg <= req_subindex;
            motor_wdata <= req_wdata;
        end
        else if (motor_busy && motor_ack)
        begin
            motor_busy <= 1'b0;
            motor_req <= 1'b0;
        end
    end

    // answers: local objects one cycle after the request, motor one cycle after ack
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            resp_valid <= 1'b0;
            resp_code <= FPOM_RESP_OK;
            resp_rdata <= 32'h00000000;
        end
        else if (motor_busy && motor_ack)
        begin
            resp_valid <= 1'b1;
            resp_code <= FPOM_RESP_OK;
            resp_rdata <= motor_write ? 32'h00000000 : motor_rdata;
        end
        else if (req_valid && is_motor)
        begin
            resp_valid <= motor_busy;
            resp_code <= FPOM_RESP_DENIED; // a second motor request while one is open is refused
            resp_rdata <= 32'h00000000;
        end
        else if (req_valid)
        begin
            resp_valid <= 1'b1;
            resp_rdata <= 32'h00000000;
            if (is_cmd)
                resp_code <= req_write ? FPOM_RESP_OK : FPOM_RESP_DENIED; // write only
            else if (is_mod && !next_ok)
                resp_code <= FPOM_RESP_UNMAPPED;
            else if (is_mod && req_write && !next_writable)
                resp_code <= FPOM_RESP_DENIED;
            else if (is_mod)
            begin
                resp_code <= FPOM_RESP_OK;
                resp_rdata <= req_write ? 32'h00000000 : next_rdata;
            end
            else
                resp_code <= FPOM_RESP_UNMAPPED;
        end
        else
            resp_valid <= 1'b0;
    end

    a_ro_write_denied: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid && req_write && is_mod && req_subindex == `FPOM_SUB_NET_MASK
        |=> resp_valid && resp_code == FPOM_RESP_DENIED)
        else $error("read-only write not refused");
    a_setup_hold: assert property (@(posedge clock) disable iff (!reset_n)
        !(req_valid && req_write && is_mod && req_subindex == `FPOM_SUB_SETUP) |=> $stable(setup_bits))
        else $error("setup bits changed without a write");
    a_save_starts: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid && req_write && is_cmd && req_wdata == `FPOM_CMD_SAVE_FLASH |=> save_request)
        else $error("save command did not raise save request");
    a_counter_step: assert property (@(posedge clock) disable iff (!reset_n)
        total_frame_evt |=> counts[3] == $past(counts[3]) + 32'h00000001)
        else $error("frame counter did not step by one");
    a_counter_hold: assert property (@(posedge clock) disable iff (!reset_n)
        !link_timeout_evt |=> $stable(counts[0]))
        else $error("timeout counter moved without event");
    a_map_frozen: assert property (@(posedge clock) disable iff (!reset_n)
        1'b1 |=> $stable(transmit_process_map) && $stable(receive_process_map))
        else $error("active cyclic map changed while running");
    a_reserved_err: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid && is_mod && req_subindex == 8'h08 |=> resp_code == FPOM_RESP_UNMAPPED)
        else $error("reserved subindex answered as mapped");
    a_node_id: assert property (@(posedge clock) disable iff (!reset_n)
        wr_mod && req_subindex == `FPOM_SUB_NET_ADDR |=> node_id == $past(req_wdata[7:0]))
        else $error("node id does not follow address word");
    a_motor_fwd: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid && is_motor && !motor_busy |=> motor_req && motor_reg == $past(req_subindex))
        else $error("motor request not forwarded");
endmodule : fpom_object_map
`default_nettype wire

// *** testbench/fpom_motor_model.sv ***
/*
 motor register file and flash copy stand-in facing the object map.
 assumes the map's clock, and a pace input set by the bench (prompt or slow).
*/
`timescale 1ns/1ns
`default_nettype none
module fpom_motor_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // motor register window
    input wire logic motor_req,
    input wire logic motor_write,
    input wire logic [7:0] motor_reg,
    input wire logic [31:0] motor_wdata,
    output logic motor_ack,
    output logic [31:0] motor_rdata,
    // flash copy and pace
    input wire logic save_request,
    output logic save_done,
    input wire logic slow
);
    logic [31:0] regs [256];
    logic [3:0] wait_cnt;
    logic [2:0] save_cnt;

    // known contents so a read never hands back an unknown
    initial
    begin
        for (int i = 0; i < 256; i++)
            regs[i] = {24'h5E5E00, i[7:0]};
    end

    // answer after 0 or 7 idle cycles; data is junk outside the ack cycle
    always @(posedge clock)
    begin
        motor_ack <= 1'b0;
        motor_rdata <= ~motor_rdata; // stale value must not look valid
        if (!reset_n)
        begin
            wait_cnt <= 4'h0;
            motor_rdata <= 32'h5A5A0F0F;
        end
        else if (motor_req && !motor_ack)
        begin
            if (wait_cnt == (slow ? 4'h7 : 4'h0))
            begin
                motor_ack <= 1'b1;
                wait_cnt <= 4'h0;
                motor_rdata <= regs[motor_reg];
                if (motor_write)
                    regs[motor_reg] <= motor_wdata;
            end
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end

    // flash copy takes a few cycles, then one done pulse
    always @(posedge clock)
    begin
        save_done <= 1'b0;
        if (!reset_n || !save_request || save_done)
            save_cnt <= 3'h0;
        else if (save_cnt == 3'h4)
            save_done <= 1'b1;
        else
            save_cnt <= save_cnt + 3'h1;
    end
endmodule : fpom_motor_model
`default_nettype wire

// *** testbench/fieldbus_parameter_object_map_tb_top.sv ***
/*
 self-checking bench of the parameter object map, acting as the network master.
 assumes the motor and flash stand-in model and the map's package.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("MISMATCH %s expected %h seen %h", what, exp, got); \
        end \
    end
module fieldbus_parameter_object_map_tb_top;
    import fpom_pkg::*;
    localparam logic [31:0] HW_HIGH = 32'hABCD1357; // arbitrary value
    localparam logic [31:0] HW_LOW = 32'h2468ACE0; // arbitrary value
    localparam logic [31:0] SERIAL = 32'h0000BEEF; // arbitrary value
    localparam logic [31:0] HWV = 32'h00000203; // arbitrary value
    localparam logic [31:0] SWV = 32'h00000405; // arbitrary value
    localparam logic [31:0] MASK = 32'hFFFF0000;
    localparam logic [31:0] GW = 32'hC0A80001;
    localparam logic [31:0] DIN = 32'hC3A50F96;
    localparam logic [31:0] STAT = 32'h00008001;
    localparam logic [15:0] CMD = 16'h0010;
    localparam logic [15:0] MOD = 16'h0011;
    localparam logic [15:0] MOT = 16'h0012;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [15:0] req_index = 16'h0000;
    logic [7:0] req_subindex = 8'h00;
    logic [31:0] req_wdata = 32'h00000000;
    logic [31:0] digital_inputs_pin = DIN;
    logic [31:0] status_bits = STAT;
    logic [3:0] evt = 4'h0;
    logic slow = 1'b0;
    logic resp_valid, motor_req, motor_write, motor_ack, save_request, save_done;
    fpom_resp_t resp_code;
    logic [31:0] resp_rdata, motor_wdata, motor_rdata, net_address_node, setup_bits, digital_outputs, cmd_word;
    logic [7:0] motor_reg, node_id;
    logic [159:0] tx_map, rx_map;
    int n_mismatch = 0;
    int check_count = 0;

    always #20 clock = ~clock;

    fpom_object_map #(.HW_ADDR_HIGH(HW_HIGH), .HW_ADDR_LOW(HW_LOW), .NET_MASK(MASK), .GATEWAY(GW),
        .SERIAL_NUMBER(SERIAL), .HW_VERSION(HWV), .SW_VERSION(SWV), .MAP_POSITIONS(5)) i_fpom_object_map (
        .clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req_write(req_write),
        .req_index(req_index), .req_subindex(req_subindex), .req_wdata(req_wdata),
        .resp_valid(resp_valid), .resp_code(resp_code), .resp_rdata(resp_rdata),
        .motor_req(motor_req), .motor_write(motor_write), .motor_reg(motor_reg),
        .motor_wdata(motor_wdata), .motor_ack(motor_ack), .motor_rdata(motor_rdata),
        .save_request(save_request), .save_done(save_done), .net_address_node(net_address_node),
        .node_id(node_id), .setup_bits(setup_bits), .digital_outputs(digital_outputs), .command_word(cmd_word),
        .digital_inputs_pin(digital_inputs_pin), .status_bits(status_bits),
        .transmit_process_map(tx_map), .receive_process_map(rx_map), .link_timeout_evt(evt[0]),
        .retry_frame_evt(evt[1]), .discard_frame_evt(evt[2]), .total_frame_evt(evt[3]));

    fpom_motor_model i_fpom_motor_model (.clock(clock), .reset_n(reset_n), .motor_req(motor_req),
        .motor_write(motor_write), .motor_reg(motor_reg), .motor_wdata(motor_wdata),
        .motor_ack(motor_ack), .motor_rdata(motor_rdata), .save_request(save_request),
        .save_done(save_done), .slow(slow));

    // inputs always move the same 2 ns after the edge
    task automatic tick;
        @(posedge clock);
        #2;
    endtask : tick

    // one acyclic request, then the answer judged; one edge gap avoids double drive
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] d, input fpom_resp_t ec, input logic [31:0] er);
        int n = 0;
        tick();
        req_valid = 1'b1;
        req_write = w;
        req_index = idx;
        req_subindex = sub;
        req_wdata = d;
        tick();
        req_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 40)
        begin
            tick();
            n++;
        end
        `CHK("resp_valid", 1'b1, resp_valid)
        `CHK("resp_code", ec, resp_code)
        `CHK("resp_rdata", er, resp_rdata)
    endtask : xfer

    task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
        xfer(1'b0, idx, sub, 32'h00000000, FPOM_RESP_OK, e);
    endtask : rd

    task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input fpom_resp_t ec);
        xfer(1'b1, idx, sub, d, ec, 32'h00000000);
    endtask : wr

    // every default except subindices 3 and 15, and every read-only value, after reset
    task automatic t_defaults;
        logic [31:0] tx[5] = '{32'h2, 32'hA, 32'hC, 32'hA9, 32'h23};
        logic [31:0] rx[5] = '{32'h2, 32'h3, 32'h5, 32'h7, 32'h0};
        for (int i = 0; i < 5; i++)
        begin
            rd(MOD, 8'h10 + i[7:0], tx[i]);
            rd(MOD, 8'h18 + i[7:0], rx[i]);
            `CHK("tx_map", tx[i], tx_map[i*32 +: 32])
            `CHK("rx_map", rx[i], rx_map[i*32 +: 32])
            if (i < 4)
                rd(MOD, 8'h23 + i[7:0], 32'h0);
        end
        rd(MOD, 8'h06, 32'h0);
        rd(MOD, 8'h07, 32'h0);
        rd(MOD, 8'h01, {16'h0000, HW_HIGH[15:0]});
        rd(MOD, 8'h02, HW_LOW);
        rd(MOD, 8'h04, MASK);
        rd(MOD, 8'h05, GW);
        rd(MOD, 8'h20, SERIAL);
        rd(MOD, 8'h21, HWV);
        rd(MOD, 8'h22, SWV);
        rd(MOD, 8'h2F, DIN);
        rd(MOD, 8'h30, STAT);
    endtask : t_defaults

    // writable words land on the pins; nothing is saved and the maps stay put
    task automatic t_writes;
        wr(MOD, 8'h03, 32'h0A0B0C2D, FPOM_RESP_OK);
        `CHK("node_id", 8'h2D, node_id)
        rd(MOD, 8'h03, 32'h0A0B0C2D);
        wr(MOD, 8'h06, 32'h80000001, FPOM_RESP_OK);
        `CHK("setup_bits", 32'h80000001, setup_bits)
        wr(MOD, 8'h07, 32'h000000F5, FPOM_RESP_OK);
        `CHK("digital_outputs", 32'h000000F5, digital_outputs)
        wr(MOD, 8'h0F, 32'h0000005A, FPOM_RESP_OK);
        `CHK("command_word", 32'h0000005A, cmd_word)
        wr(MOD, 8'h10, 32'h00000014, FPOM_RESP_OK);
        rd(MOD, 8'h10, 32'h00000014);
        wr(MOD, 8'h1C, 32'h00000011, FPOM_RESP_OK);
        rd(MOD, 8'h1C, 32'h00000011);
        `CHK("tx_map", 32'h2, tx_map[31:0])
        `CHK("rx_map", 32'h0, rx_map[159:128])
        `CHK("save_request", 1'b0, save_request)
    endtask : t_writes

    // read-only, reserved and unknown places refuse and change nothing
    task automatic t_refused;
        logic [7:0] ro[13] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
            8'h26, 8'h2F, 8'h30};
        logic [7:0] rs[10] = '{8'h08, 8'h0E, 8'h15, 8'h17, 8'h1D, 8'h1F, 8'h27, 8'h2E, 8'h31, 8'h3F};
        foreach (ro[i])
            wr(MOD, ro[i], 32'hFFFFFFFF, FPOM_RESP_DENIED);
        foreach (rs[i])
        begin
            wr(MOD, rs[i], 32'hFFFFFFFF, FPOM_RESP_UNMAPPED);
            xfer(1'b0, MOD, rs[i], 32'h0, FPOM_RESP_UNMAPPED, 32'h0);
        end
        xfer(1'b0, CMD, 8'h00, 32'h0, FPOM_RESP_DENIED, 32'h0);
        wr(16'h0013, 8'h00, 32'h1, FPOM_RESP_UNMAPPED);
        rd(MOD, 8'h01, {16'h0000, HW_HIGH[15:0]});
        rd(MOD, 8'h23, 32'h0);
        `CHK("setup_bits", 32'h80000001, setup_bits)
    endtask : t_refused

    // only code 16 asks for the flash copy, which the far side then finishes
    task automatic t_command;
        int n = 0;
        wr(CMD, 8'h00, 32'h00000001, FPOM_RESP_OK);
        `CHK("save_request", 1'b0, save_request)
        wr(CMD, 8'h00, 32'h00000010, FPOM_RESP_OK);
        while (save_request !== 1'b1 && n < 3)
        begin
            tick();
            n++;
        end
        `CHK("save_request", 1'b1, save_request)
        n = 0;
        while (save_request !== 1'b0 && n < 12)
        begin
            tick();
            n++;
        end
        `CHK("save_request", 1'b0, save_request)
        `CHK("tx_map", 32'h2, tx_map[31:0])
    endtask : t_command

    // both ends of the motor window, prompt and slow far side
    task automatic t_motor;
        for (int s = 0; s < 2; s++)
        begin
            slow = s[0];
            wr(MOT, 8'hFF, 32'hCAFE0001 + s, FPOM_RESP_OK);
            rd(MOT, 8'hFF, 32'hCAFE0001 + s);
            wr(MOT, 8'h00, 32'h0BADF00D + s, FPOM_RESP_OK);
            rd(MOT, 8'h00, 32'h0BADF00D + s);
        end
        rd(MOT, 8'h23, 32'h5E5E0023);
        // slow far side: a second read while the first is open is refused
        tick();
        req_valid = 1'b1;
        req_subindex = 8'h01;
        tick();
        tick();
        req_valid = 1'b0;
        `CHK("resp_valid", 1'b1, resp_valid)
        `CHK("resp_code", FPOM_RESP_DENIED, resp_code)
        repeat (8) tick();
        `CHK("resp_rdata", 32'h5E5E0001, resp_rdata)
    endtask : t_motor

    // counter k gets k+1 pulses; then a second reset clears the timeout counter and setup bits and leaves the transmit map at its default
    task automatic t_counters;
        for (int k = 0; k < 4; k++)
        begin
            repeat (k + 1)
            begin
                tick();
                evt[k] = 1'b1;
                tick();
                evt[k] = 1'b0;
            end
        end
        for (int k = 0; k < 4; k++)
        begin
            rd(MOD, 8'h23 + k[7:0], k + 1);
            rd(MOD, 8'h23 + k[7:0], k + 1);
        end
        reset_n = 1'b0;
        repeat (5) tick();
        reset_n = 1'b1;
        rd(MOD, 8'h23, 32'h0);
        `CHK("setup_bits", 32'h0, setup_bits)
        `CHK("tx_map", 32'h23, tx_map[159:128])
    endtask : t_counters

    task automatic print_verdict;
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict

    // main sequence
    initial
    begin
        repeat (5) tick();
        reset_n = 1'b1;
        t_defaults();
        t_writes();
        t_refused();
        t_command();
        t_motor();
        t_counters();
        print_verdict();
    end

    // watchdog, far beyond the few hundred cycles the run needs
    initial
    begin
        #400000;
        n_mismatch++;
        print_verdict();
    end
endmodule : fieldbus_parameter_object_map_tb_top
`default_nettype wire
